//--- rtl/can_tx_mailbox_status.sv
// transmit mailbox status register with abort handling and apb slave
//
// What this block does
// - flag the lowest-priority pending box, bits 31..29
// - single pending box clears all lowest flags
// - empty flag set while box holds nothing
// - status reads 0x1c000000 out of reset
// - code gives next empty box to fill
// - all empty: code gives box of newest request, in either ranking mode
// - abort bit set by software, cleared when idle
// - abort on an empty box does nothing
// - bus error on attempt sets error flag
// - lost arbitration on attempt sets flag
// - success flag follows latest attempt outcome
// - finished send or abort sets completed flag
// - completed flag cleared by write-one or request
// - clearing completed also clears its outcome flags
// - bits 22..20 always read zero
// - order option ranks boxes by request age
`timescale 1ns/1ps
module can_tx_mailbox_status
    import can_tx_status_pkg::*;
#(
    parameter int unsigned BOXES = NUM_BOXES           // fixed by the register layout
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  prio_by_order,   // 1: rank by request order
    input  wire logic [BOXES-1:0]      tx_req,          // engine accepted transmit_request
    input  wire logic [BOXES-1:0]      tx_busy,         // box frame is on the bus
    input  wire logic [BOXES-1:0]      attempt_end,     // send attempt finished
    input  wire attempt_t              attempt,         // outcome of that attempt
    input  wire msg_id_t [BOXES-1:0]   box_id,          // identifiers of queued frames
    output logic      [BOXES-1:0]      tx_pending,      // boxes holding a frame
    output logic      [BOXES-1:0]      abort_active,    // abort requested, to engine
    output logic                       irq              // level, unmasked event pending
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (BOXES != NUM_BOXES) begin : g_bad_boxes
        $error("mailbox count must match the status word layout");
    end

    // ************************************************************
    // helpers
    // ************************************************************
    // bit position of a per-box field
    function automatic int unsigned fpos(input int unsigned box, input int unsigned fld);
        fpos = box * BOX_STRIDE + fld;
    endfunction

    // number of the first set bit, lowest first
    function automatic logic [1:0] first_set(input logic [2:0] v);
        first_set = v[0] ? 2'h0 : (v[1] ? 2'h1 : (v[2] ? 2'h2 : 2'h0));
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [BOXES-1:0]  pending_q, pending_d;            // box holds a frame
    logic [BOXES-1:0]  done_q, done_d;                  // request completed
    logic [BOXES-1:0]  ok_q, ok_d;                      // last attempt succeeded
    logic [BOXES-1:0]  alst_q, alst_d;                  // arbitration lost
    logic [BOXES-1:0]  terr_q, terr_d;                  // transmission error
    logic [BOXES-1:0]  abort_q, abort_d;                // abort requested
    logic [BOXES-1:0]  done_set;                        // completion event this cycle
    logic [BOXES-1:0]  older_q [BOXES];                 // [i][j]: i requested before j
    logic [BOXES-1:0]  older_d [BOXES];
    logic [BOXES-1:0]  lower   [BOXES];                 // [i][j]: i ranks below j
    logic [2:0]        irq_st_q, irq_st_d;              // sticky events
    logic [2:0]        irq_mask_q;                      // event enables
    logic [31:0]       prdata_q;                        // captured read data
    logic              ready_q;                         // access phase answer

    // ************************************************************
    // apb decode
    // ************************************************************
    // a transfer completes in its second access cycle
    wire        acc      = psel & penable & ready_q;     // completing transfer
    wire        hit_st   = (paddr == ADDR_TX_STATUS);
    wire        hit_ist  = (paddr == ADDR_IRQ_STAT);
    wire        hit_imsk = (paddr == ADDR_IRQ_MASK);
    wire        unmapped = ~(hit_st | hit_ist | hit_imsk);
    wire        wr_st    = acc & pwrite & hit_st;
    wire [31:0] wr_ones  = wr_st ? pwdata : 32'h0;      // write-one strobes
    // read of the event register clears only what it returned
    wire        rd_ist   = acc & ~pwrite & hit_ist;

    // ************************************************************
    // per-box flags
    // ************************************************************
    for (genvar b = 0; b < BOXES; b++) begin : g_box
        // write-one strobes of this box's flag bits
        wire w_done  = wr_ones[fpos(b, FLD_DONE)];
        wire w_ok    = wr_ones[fpos(b, FLD_OK)];
        wire w_alst  = wr_ones[fpos(b, FLD_ALST)];
        wire w_terr  = wr_ones[fpos(b, FLD_TERR)];
        wire w_abort = wr_ones[fpos(b, FLD_ABORT)];
        wire fail    = attempt_end[b] & ~attempt.ok;
        // abort lands when the box is off the bus or its attempt just failed
        wire cancel  = abort_q[b] & pending_q[b] & (~tx_busy[b] | fail);
        // a successful attempt ends the request, a failed one retries
        wire finish  = pending_q[b] & attempt_end[b] & attempt.ok;
        wire clr_all = w_done | tx_req[b];

        // completion event, from a sent frame or a landed abort
        assign done_set[b] = finish | cancel;

        // next state, hardware set wins over any clear
        always_comb begin
            pending_d[b] = pending_q[b];
            if (tx_req[b]) begin
                pending_d[b] = 1'b1;
            end else if (done_set[b]) begin
                pending_d[b] = 1'b0;
            end
            done_d[b] = done_set[b] | (done_q[b] & ~clr_all);
            ok_d[b]   = attempt_end[b] ? attempt.ok
                                       : (ok_q[b] & ~clr_all & ~w_ok);
            alst_d[b] = (attempt_end[b] & attempt.arb_lost)
                        | (alst_q[b] & ~clr_all & ~w_alst);
            terr_d[b] = (attempt_end[b] & attempt.bus_err)
                        | (terr_q[b] & ~clr_all & ~w_terr);
            // ignored on an empty box, dropped once the box goes idle
            abort_d[b] = (abort_q[b] | (w_abort & pending_q[b])) & pending_d[b];
        end

        // request order matrix, newest request ranks lowest
        for (genvar j = 0; j < BOXES; j++) begin : g_age
            always_comb begin
                if (b == j) begin
                    older_d[b][j] = 1'b0;
                end else if (tx_req[b] & tx_req[j]) begin
                    older_d[b][j] = (b < j);
                end else if (tx_req[j]) begin
                    older_d[b][j] = 1'b1;
                end else if (tx_req[b]) begin
                    older_d[b][j] = 1'b0;
                end else begin
                    older_d[b][j] = older_q[b][j];
                end
            end
            // ranking: order mode, else higher identifier, tie to higher box
            assign lower[b][j] = (b != j) & (prio_by_order ? older_q[j][b]
                               : ((box_id[b] > box_id[j])
                               | ((box_id[b] == box_id[j]) & (b > j))));
            // reset order leaves box 0 the newest
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    older_q[b][j] <= (b > j) ? 1'b1 : 1'b0;
                end else begin
                    older_q[b][j] <= older_d[b][j];
                end
            end
        end
    end

    // ************************************************************
    // priority, empty and code fields
    // ************************************************************
    logic [BOXES-1:0] lowest_pend;                      // lowest among pending
    logic [BOXES-1:0] lowest_age;                       // newest request overall

    // compare each box with every other
    always_comb begin
        for (int i = 0; i < BOXES; i++) begin
            lowest_pend[i] = pending_q[i];
            lowest_age[i]  = 1'b1;
            for (int j = 0; j < BOXES; j++) begin
                if (i != j) begin
                    lowest_pend[i] = lowest_pend[i] & (~pending_q[j] | lower[i][j]);
                    lowest_age[i]  = lowest_age[i] & older_q[j][i];
                end
            end
        end
    end

    // two or more boxes pending
    wire             multi        = (pending_q[0] & pending_q[1]) | (pending_q[0] & pending_q[2])
                                  | (pending_q[1] & pending_q[2]);
    wire [2:0]       lowest_flags = multi ? lowest_pend : 3'h0;
    // a box is empty whenever it holds no frame
    wire [2:0]       empty        = ~pending_q;
    wire [1:0]       code         = (&empty) ? first_set(lowest_age)
                                             : first_set(empty);

    // ************************************************************
    // status word, reserved bits stay zero
    // ************************************************************
    logic [31:0] st_word;
    always_comb begin
        st_word = 32'h0;
        st_word[ST_LOWEST_LSB +: 3] = lowest_flags;
        st_word[ST_EMPTY_LSB +: 3]  = empty;
        st_word[ST_CODE_LSB +: 2]   = code;
        for (int i = 0; i < BOXES; i++) begin
            st_word[fpos(i, FLD_DONE)]  = done_q[i];
            st_word[fpos(i, FLD_OK)]    = ok_q[i];
            st_word[fpos(i, FLD_ALST)]  = alst_q[i];
            st_word[fpos(i, FLD_TERR)]  = terr_q[i];
            st_word[fpos(i, FLD_ABORT)] = abort_q[i];
        end
    end

    // ************************************************************
    // interrupt events, read clears only what was returned
    // ************************************************************
    // an event landing during the read survives, since set wins
    assign irq_st_d = done_set | (irq_st_q & ~(rd_ist ? prdata_q[2:0] : 3'h0));

    // read mux
    wire [31:0] rd_mux = hit_st   ? st_word
                       : hit_ist  ? {29'h0, irq_st_q}
                       : hit_imsk ? {29'h0, irq_mask_q}
                       : 32'h0;

    // ************************************************************
    // registers
    // ************************************************************
    // flag state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_q <= 3'h0;
            done_q    <= 3'h0;
            ok_q      <= 3'h0;
            alst_q    <= 3'h0;
            terr_q    <= 3'h0;
            abort_q   <= 3'h0;
        end else begin
            pending_q <= pending_d;
            done_q    <= done_d;
            ok_q      <= ok_d;
            alst_q    <= alst_d;
            terr_q    <= terr_d;
            abort_q   <= abort_d;
        end
    end

    // interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q   <= 3'h0;
            irq_mask_q <= IRQ_MASK_RESET;
        end else begin
            irq_st_q   <= irq_st_d;
            if (acc & pwrite & hit_imsk) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end

    // one wait state, read data captured in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q  <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            ready_q  <= psel & penable & ~ready_q;
            if (psel & penable & ~ready_q & ~pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata       = prdata_q;
    assign pready       = ready_q;
    assign pslverr      = ready_q & unmapped;
    assign tx_pending   = pending_q;
    assign abort_active = abort_q;
    assign irq          = |(irq_st_q & irq_mask_q);

    // ************************************************************
    // assertions
    // ************************************************************
    // all checks on the bus clock, off during reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_lowest_multi: assert property (multi |-> $onehot(lowest_flags) && |(lowest_flags & pending_q))
        else $error("lowest flag not on one pending box");
    chk_lowest_single: assert property ($onehot0(pending_q) |-> lowest_flags == 3'h0)
        else $error("lowest flags set with one pending box");
    chk_code_empty: assert property ((|empty && !(&empty)) |-> empty[code])
        else $error("code names a full box");
    chk_rsvd_zero: assert property (ready_q && hit_st && !pwrite |-> prdata_q[ST_RSVD_MSB:ST_RSVD_LSB] == 3'h0)
        else $error("reserved bits read nonzero");
    chk_ro_fields: assert property (wr_st && tx_req == 3'h0 && done_set == 3'h0 |=> $stable(empty))
        else $error("write changed empty flags");
    chk_irq_event: assert property ((done_set & irq_mask_q) != 3'h0 && !(acc && pwrite && hit_imsk) |=> irq)
        else $error("unmasked completion raised no interrupt");

    // per-box checks
    for (genvar b = 0; b < BOXES; b++) begin : g_chk
        chk_empty_req: assert property (tx_req[b] |=> !empty[b] ##1 (empty[b] -> $past(done_set[b])))
            else $error("empty flag wrong after request");
        chk_abort_ignored: assert property (wr_ones[fpos(b, FLD_ABORT)] && !pending_q[b] && !abort_q[b] |=> !abort_q[b])
            else $error("abort latched on empty box");
        chk_abort_idle: assert property (abort_q[b] && pending_q[b] && !tx_busy[b] |=> done_q[b] && !pending_q[b] && !abort_q[b])
            else $error("abort not completed while idle");
        chk_abort_wait: assert property (abort_q[b] && pending_q[b] && tx_busy[b] && !attempt_end[b] |=> abort_q[b] && pending_q[b])
            else $error("abort dropped while frame on bus");
        chk_err_set: assert property (attempt_end[b] && attempt.bus_err |=> terr_q[b])
            else $error("error flag not set");
        chk_alst_set: assert property (attempt_end[b] && attempt.arb_lost |=> alst_q[b])
            else $error("arbitration flag not set");
        chk_ok_track: assert property (attempt_end[b] |=> ok_q[b] == $past(attempt.ok))
            else $error("success flag does not follow attempt");
        chk_done_success: assert property (pending_q[b] && attempt_end[b] && attempt.ok |=> done_q[b] && !pending_q[b])
            else $error("completion not flagged");
        chk_done_clear: assert property (wr_ones[fpos(b, FLD_DONE)] && !done_set[b] && !attempt_end[b]
                                         |=> !done_q[b] && !ok_q[b] && !alst_q[b] && !terr_q[b])
            else $error("write-one clear incomplete");
        chk_order_rank: assert property (prio_by_order && tx_req == (3'h1 << b) && !pending_q[b] && |pending_q
                                         && done_set == 3'h0 |=> !prio_by_order || lowest_flags[b])
            else $error("newest request not lowest");
    end

    chk_reset_word: assert property ($rose(ready_q) && hit_st && !pwrite && $past(pending_q == 3'h0)
                                     && $past(done_q == 3'h0) && $past(abort_q == 3'h0)
                                     |-> prdata_q[31:26] == TX_STATUS_RESET[31:26])
        else $error("idle status word wrong");

    // main scenarios
    cov_abort: cover property (abort_q[0] ##1 done_q[0]);
    cov_abort_wait: cover property (abort_q[0] && tx_busy[0]);
    cov_multi: cover property (&pending_q);
    cov_irq:   cover property (irq ##[1:20] !irq);

endmodule // can_tx_mailbox_status

//--- rtl/can_tx_status_pkg.sv
// constants and types for the transmit mailbox status block
package can_tx_status_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int unsigned NUM_BOXES  = 3;             // transmit mailboxes
    localparam int unsigned ADDR_W     = 8;             // apb address width
    localparam int unsigned ID_W       = 29;            // message identifier width

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_TX_STATUS = 8'h08;  // transmit_mailbox_status
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 8'h20;  // sticky events, read clears
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 8'h24;  // event enables

    // ************************************************************
    // status word layout
    // ************************************************************
    localparam int unsigned ST_LOWEST_LSB = 29;         // lowest-priority flags 31:29
    localparam int unsigned ST_EMPTY_LSB  = 26;         // empty flags 28:26
    localparam int unsigned ST_CODE_LSB   = 24;         // mailbox code 25:24
    localparam int unsigned ST_RSVD_LSB   = 20;         // reserved 22:20
    localparam int unsigned ST_RSVD_MSB   = 22;
    localparam int unsigned BOX_STRIDE    = 8;          // per-box byte of flags
    localparam int unsigned FLD_DONE      = 0;          // request completed
    localparam int unsigned FLD_OK        = 1;          // last attempt succeeded
    localparam int unsigned FLD_ALST      = 2;          // arbitration lost
    localparam int unsigned FLD_TERR      = 3;          // transmission error
    localparam int unsigned FLD_ABORT     = 7;          // abort request

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] TX_STATUS_RESET = 32'h1c00_0000;
    localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef logic [ID_W-1:0] msg_id_t;                  // identifier of a queued frame
    typedef struct packed {
        logic ok;                                       // frame went out
        logic arb_lost;                                 // lost arbitration
        logic bus_err;                                  // bus error
    } attempt_t;                                        // outcome of one send attempt
endpackage

//--- testbench/can_engine_model.sv
// behavioural model of the can bus engine that feeds the mailbox status block
`timescale 1ns/1ps
module can_engine_model
    import can_tx_status_pkg::*;
(
    input  wire logic     pclk,
    output logic [2:0]    tx_req,        // accepted transmit request, one pulse
    output logic [2:0]    tx_busy,       // frame on the bus
    output logic [2:0]    attempt_end,   // attempt finished, one pulse
    output attempt_t      attempt,       // outcome, valid with attempt_end only
    output msg_id_t [2:0] box_id         // identifier per box
);
    // ************************************************************
    // engine actions, all launched just after a rising edge
    // ************************************************************
    initial begin
        tx_req      = 3'h0;
        tx_busy     = 3'h0;
        attempt_end = 3'h0;
        attempt     = 3'h7;
        box_id      = '0;
    end
    // load an identifier, lower value ranks higher
    task automatic set_id(input int b, input msg_id_t id);
        @(posedge pclk);
        box_id[b] <= id;
    endtask
    // frame of box b held on the bus, or released
    task automatic set_busy(input int b, input logic v);
        @(posedge pclk);
        tx_busy[b] <= v;
    endtask
    // one-cycle request pulse for box b
    task automatic request(input int b);
        @(posedge pclk);
        tx_req <= 3'h1 << b;
        @(posedge pclk);
        tx_req <= 3'h0;
    endtask
    // busy for a cycle, then one attempt outcome
    task automatic finish(input int b, input attempt_t r);
        @(posedge pclk);
        tx_busy[b] <= 1'b1;
        @(posedge pclk);
        tx_busy[b]  <= 1'b0;
        attempt_end <= 3'h1 << b;
        attempt     <= r;
        @(posedge pclk);
        attempt_end <= 3'h0;
        attempt     <= ~r;           // outcome lines not held after the pulse
    endtask
endmodule // can_engine_model

//--- testbench/tb_can_tx_mailbox_status.sv
// self-checking bench for the transmit mailbox status block
`timescale 1ns/1ps
module tb_can_tx_mailbox_status;
    import can_tx_status_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, prio_by_order, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rdata;
    logic [2:0]        tx_req, tx_busy, attempt_end, tx_pending, abort_active;
    attempt_t          attempt;
    msg_id_t [2:0]     box_id;
    int                fail_count, compares;
    localparam logic [31:0] NO_CODE = 32'hfcff_ffff;   // hides the mailbox code field

    can_tx_mailbox_status u_can_tx_mailbox_status (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prio_by_order(prio_by_order), .tx_req(tx_req),
        .tx_busy(tx_busy), .attempt_end(attempt_end), .attempt(attempt), .box_id(box_id),
        .tx_pending(tx_pending), .abort_active(abort_active), .irq(irq));
    can_engine_model u_can_engine_model (.pclk(pclk), .tx_req(tx_req), .tx_busy(tx_busy),
        .attempt_end(attempt_end), .attempt(attempt), .box_id(box_id));

    // ************************************************************
    // tasks
    // ************************************************************
    task stop_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            stop_test();
        end
        rdata = pslverr ? 32'hdead_0000 | prdata : prdata;   // error marks the data
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rdata & m, exp & m);
    endtask
    // irq sampled mid-cycle, after the edge's updates
    task automatic chk_irq(input logic e);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // ************************************************************
    // clock, reset and sequence
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        presetn       = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 8'h00;
        pwdata        = 32'h0;
        prio_by_order = 1'b0;
        fail_count    = 0;
        compares      = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_TX_STATUS, 32'h1c00_0000, 32'hffff_ffff);
        rd(ADDR_IRQ_MASK, 32'h0, 32'hffff_ffff);
        apb(1'b1, ADDR_TX_STATUS, 32'hffff_ffff);
        rd(ADDR_TX_STATUS, 32'h1c00_0000, 32'hffff_ffff);
        $display("reset and read-only test done");
        u_can_engine_model.set_id(0, 29'h9);
        u_can_engine_model.set_id(1, 29'h5);
        u_can_engine_model.request(0);
        u_can_engine_model.request(1);
        rd(ADDR_TX_STATUS, 32'h3200_0000, 32'hffff_ffff);
        @(posedge pclk);
        prio_by_order <= 1'b1;
        rd(ADDR_TX_STATUS, 32'h5200_0000, 32'hffff_ffff);
        $display("priority test done");
        u_can_engine_model.finish(1, 3'b100);
        chk_irq(1'b0);
        rd(ADDR_TX_STATUS, 32'h1800_0300, NO_CODE);
        apb(1'b1, ADDR_IRQ_MASK, 32'h7);
        chk_irq(1'b1);
        rd(ADDR_IRQ_STAT, 32'h2, 32'hffff_ffff);
        chk_irq(1'b0);
        u_can_engine_model.request(1);
        rd(ADDR_TX_STATUS, 32'h5200_0000, 32'hffff_ffff);
        $display("completion and interrupt test done");
        u_can_engine_model.request(2);
        u_can_engine_model.finish(2, 3'b001);
        rd(ADDR_TX_STATUS, 32'h8008_0000, NO_CODE);
        u_can_engine_model.finish(2, 3'b010);
        rd(ADDR_TX_STATUS, 32'h800c_0000, NO_CODE);
        u_can_engine_model.finish(2, 3'b100);
        rd(ADDR_TX_STATUS, 32'h520f_0000, 32'hffff_ffff);
        apb(1'b1, ADDR_TX_STATUS, 32'h0001_0000);
        rd(ADDR_TX_STATUS, 32'h5200_0000, 32'hffff_ffff);
        rd(ADDR_IRQ_STAT, 32'h4, 32'hffff_ffff);
        $display("attempt outcome test done");
        u_can_engine_model.request(2);
        apb(1'b1, ADDR_TX_STATUS, 32'h0080_0000);
        rd(ADDR_TX_STATUS, 32'h5201_0000, 32'hffff_ffff);
        apb(1'b1, ADDR_TX_STATUS, 32'h0000_8000);
        rd(ADDR_TX_STATUS, 32'h1801_0100, NO_CODE);
        chk({29'h0, tx_pending}, 32'h1);
        u_can_engine_model.set_busy(0, 1'b1);
        apb(1'b1, ADDR_TX_STATUS, 32'h0000_0080);
        rd(ADDR_TX_STATUS, 32'h1901_0180, 32'hffff_ffff);
        chk({29'h0, abort_active}, 32'h1);
        u_can_engine_model.finish(0, 3'b010);
        rd(ADDR_TX_STATUS, 32'h1e01_0105, 32'hffff_ffff);
        chk({29'h0, tx_pending}, 32'h0);
        chk({29'h0, abort_active}, 32'h0);
        $display("abort test done");
        rd(8'h30, 32'hdead_0000, 32'hffff_ffff);
        $display("unmapped access test done");
        stop_test();
    end
endmodule // tb_can_tx_mailbox_status
